// File: pkg/pesig_consts.svh
// register offsets, field positions, reset values and flag encodings of the poison signaller
// assumes inclusion through the package or a design file, once per compilation unit
`ifndef PESIG_CONSTS_SVH
`define PESIG_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PESIG_OFF_FEAT_LO    12'h000
`define PESIG_OFF_FEAT_HI    12'h004
`define PESIG_OFF_SUPPORT    12'h008
`define PESIG_OFF_PSTATE     12'h00C
`define PESIG_OFF_CACHE_CHK  12'h010
`define PESIG_OFF_BUS_CHK    12'h014
`define PESIG_OFF_IRQ_STAT   12'h018
`define PESIG_OFF_IRQ_MASK   12'h01C
`define PESIG_OFF_CONTROL    12'h020
`define PESIG_OFF_COUNT      12'h024

// ------------------------------------------------------------
// feature set 0 bit positions (64-bit word)
// ------------------------------------------------------------
`define PESIG_FEAT_PROMOTE   53
`define PESIG_FEAT_CE_PROMO  60
`define PESIG_FEAT_RESET     64'h0000_0000_0000_0000

// ------------------------------------------------------------
// state parameter and check record fields
// ------------------------------------------------------------
`define PESIG_ST_FIXED       0
`define PESIG_ST_USTOP       1
`define PESIG_ST_INTACT      2
`define PESIG_ST_RESUME      3
`define PESIG_ST_PRECISE     4
`define PESIG_CHK_POISON     23
// promoted encoding: fixed 0, ustop 0, intact 1, resumable 1, precise 0
`define PESIG_ST_PROMOTED    5'h0C
`define PESIG_ST_CORRECTED   5'h01

// ------------------------------------------------------------
// interrupt status bits
// ------------------------------------------------------------
`define PESIG_IRQ_CE         0
`define PESIG_IRQ_ABORT      1
`define PESIG_IRQ_OTHER      2
`define PESIG_IRQ_W          3

`endif

// File: pkg/pesig_pkg.sv
// types of the poison event signaller
// assumes the constants header is found on the include path
`include "pesig_consts.svh"
package pesig_pkg;
  // source of a poisoning event
  typedef enum logic [1:0] {
    PESIG_SRC_NONE,
    PESIG_SRC_CACHE,
    PESIG_SRC_BUS
  } pesig_src_t;

  // bus slave sequencing
  typedef enum logic [1:0] {
    PESIG_BUS_IDLE,
    PESIG_BUS_WRESP,
    PESIG_BUS_RRESP
  } pesig_bus_t;

  typedef logic [4:0] pesig_pstate_t;
endpackage

// File: pkg/pesig_evt_if.sv
// carrier between classifier and top: one classified event per cycle
// assumes a single clock shared by both ends
`timescale 1ns/1ns
interface pesig_evt_if;
  import pesig_pkg::*;
  logic          valid;
  logic          promote;
  logic          resumable;
  pesig_pstate_t pstate;
  logic          poison_cache;
  logic          poison_bus;
  logic          other;

  modport producer (output valid, output promote, output resumable, output pstate,
                    output poison_cache, output poison_bus, output other);
  modport consumer (input valid, input promote, input resumable, input pstate,
                    input poison_cache, input poison_bus, input other);
endinterface

// File: logic/pesig_classify.sv
// combinational classifier of one poisoning event into its signalling and flags
// assumes inputs are already synchronised to the module clock
`timescale 1ns/1ns
`include "pesig_consts.svh"
module pesig_classify (
  input  wire logic        promote_en,
  input  wire logic        ev_valid,
  input  wire logic        ev_consumed,
  input  wire logic        ev_cache,
  input  wire logic        ev_other,
  pesig_evt_if.producer    evt
);
  import pesig_pkg::*;

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  // only poison that the local processor does not consume is handled here
  wire logic unconsumed = ev_valid & ~ev_consumed;

  assign evt.valid        = unconsumed;
  assign evt.promote      = promote_en;
  assign evt.pstate       = promote_en ? `PESIG_ST_PROMOTED
                                       : `PESIG_ST_CORRECTED;
  assign evt.poison_cache = unconsumed & ev_cache;
  assign evt.poison_bus   = unconsumed & ~ev_cache;
  assign evt.other        = ev_other;
  // resumable only with the promoted encoding and a lone poison error
  assign evt.resumable    = promote_en & ~ev_other;
endmodule

// File: logic/pesig_top.sv
// poison event signaller: classification, error records, feature set and bus slave
// assumes AXI4-Lite master on the same clock, event inputs from on-clock cache logic
// assumes at most one write and one read in flight, as a lite master keeps
// assumes each event input is a one-cycle pulse, qualified in that cycle
//
// Functional notes
// - poison moved between levels and not consumed locally is an unconsumed event.
// - a transfer of poison-marked uncorrectable data may raise a reporting event.
// - promotion control lives in bit 53 of feature set 0.
// - promotion bit zero signals a corrected-error interrupt; this is the default.
// - promotion bit one signals a machine-check abort, data treated lost.
// - without promotion support the supplied bit value is ignored.
// - bit 60 corrected-error promotion never affects poison event signalling.
// - corrected-error signalling sets the fixed flag of the state parameter.
// - promoted abort reports fixed 0, ustop 0, intact 1, resumable 1, precise 0.
// - promoted, encoded, poison flag set and no other error gives resumable.
// - poison flag bit 23 of cache check record set when line poisoned unconsumed.
`timescale 1ns/1ns
`include "pesig_consts.svh"
module pesig_top #(
  parameter bit SUPPORT_PROMOTE = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ev_valid,
  input  wire logic        ev_consumed,
  input  wire logic        ev_cache,
  input  wire logic        ev_other,
  output logic             corrected_error_interrupt,
  output logic             machine_check_abort,
  output logic             irq,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import pesig_pkg::*;

  // register map, one aligned word each:
  //   feature low and high words; promotion is high-word bit 21
  //   support word: bit 21 says promotion can be enabled
  //   state word: bit 31 marks a captured event, bits 4:0 the flags
  //   cache and bus check words: bit 23 is the poison flag
  //   status (write one to clear) and a mask of the same layout
  //   status bit 2 marks an event that came with another error
  //   control: bit 0 reads resumable, a written one clears records
  //   event count: saturates at all ones
  // unmapped addresses answer with a slave error and read as zero
  // only the latest event is kept: read records before the next one

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [63:0]              feat_q;
  pesig_pstate_t            pstate_q;
  logic [31:0]              cache_chk_q;
  logic [31:0]              bus_chk_q;
  logic [`PESIG_IRQ_W-1:0]  stat_q;
  logic [`PESIG_IRQ_W-1:0]  mask_q;
  logic                     resumable_q;
  logic                     valid_q;
  logic [15:0]              count_q;
  logic [11:0]              awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     aw_have_q;
  logic                     w_have_q;
  logic [11:0]              araddr_q;
  pesig_bus_t               bus_q;

  // one classified event per cycle travels to the records and
  // signalling logic below as a single bundle
  pesig_evt_if evt ();

  // ------------------------------------------------------------
  // event classification
  // ------------------------------------------------------------
  // pure decode, so a pulse leaves one cycle after its event;
  // registering here would cost every signal a cycle
  // the feature bit is the only steering input; bit 60 is not looked at
  wire logic promote_en = feat_q[`PESIG_FEAT_PROMOTE];

  pesig_classify u_classify (
    .promote_en  (promote_en),
    .ev_valid    (ev_valid),
    .ev_consumed (ev_consumed),
    .ev_cache    (ev_cache),
    .ev_other    (ev_other),
    .evt         (evt)
  );

  // ------------------------------------------------------------
  // write channel decode
  // ------------------------------------------------------------
  // byte-lane merge of written data into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // a write commits once address and data are both held and no
  // response waits; they may arrive in either order
  // the response is raised on the same edge as the commit
  // byte enables are honoured, so a partial write of a feature
  // word leaves the other bytes as they were
  wire logic        wr_go      = aw_have_q & w_have_q & (bus_q == PESIG_BUS_IDLE);
  wire logic        wr_feat_lo = wr_go & (awaddr_q == `PESIG_OFF_FEAT_LO);
  wire logic        wr_feat_hi = wr_go & (awaddr_q == `PESIG_OFF_FEAT_HI);
  wire logic        wr_stat    = wr_go & (awaddr_q == `PESIG_OFF_IRQ_STAT);
  wire logic        wr_mask    = wr_go & (awaddr_q == `PESIG_OFF_IRQ_MASK);
  wire logic        wr_ctrl    = wr_go & (awaddr_q == `PESIG_OFF_CONTROL);
  wire logic        wr_known   = wr_feat_lo | wr_feat_hi | wr_stat | wr_mask | wr_ctrl;
  wire logic [31:0] hi_new     = merge(feat_q[63:32], wdata_q, wstrb_q);
  // unsupported promotion keeps the bit at zero whatever software writes
  wire logic [31:0] hi_keep    = SUPPORT_PROMOTE ? hi_new
                               : (hi_new & ~(32'h1 << (`PESIG_FEAT_PROMOTE - 32)));
  // control write with bit 0 clears the error records
  wire logic        rec_clr    = wr_ctrl & wstrb_q[0] & wdata_q[0];

  // ------------------------------------------------------------
  // feature set 0
  // ------------------------------------------------------------
  // the halves are separate words; changing promotion needs only
  // the high word, and bit 60 is stored but steers nothing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      feat_q <= `PESIG_FEAT_RESET;  // promotion off by default
    end else if (wr_feat_lo) begin
      feat_q[31:0] <= merge(feat_q[31:0], wdata_q, wstrb_q);
    end else if (wr_feat_hi) begin
      feat_q[63:32] <= hi_keep;
    end
  end

  // ------------------------------------------------------------
  // error records: event capture wins over a record clear
  // ------------------------------------------------------------
  // losing a record is worse than clearing once more, so an event
  // beats a clear in the same cycle; software then sees valid set
  // the cache and bus poison flags are written together per event
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pstate_q    <= '0;
      cache_chk_q <= '0;
      bus_chk_q   <= '0;
      resumable_q <= 1'b0;
      valid_q     <= 1'b0;
    end else if (evt.valid) begin
      pstate_q    <= evt.pstate;
      valid_q     <= 1'b1;
      cache_chk_q[`PESIG_CHK_POISON] <= evt.poison_cache;
      bus_chk_q[`PESIG_CHK_POISON]   <= evt.poison_bus;
      resumable_q <= evt.resumable;
    end else if (rec_clr) begin
      pstate_q    <= '0;
      cache_chk_q <= '0;
      bus_chk_q   <= '0;
      resumable_q <= 1'b0;
      valid_q     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // signalling outputs: one-cycle pulses per event
  // ------------------------------------------------------------
  // exactly one pulse per unconsumed event; consumed poison
  // raises neither, and both pulses leave from flip-flops
  // so the pins never glitch on a decode change
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      corrected_error_interrupt <= 1'b0;
      machine_check_abort       <= 1'b0;
    end else begin
      corrected_error_interrupt <= evt.valid & ~evt.promote;
      machine_check_abort       <= evt.valid & evt.promote;
    end
  end

  // ------------------------------------------------------------
  // sticky status, write-one-to-clear; a new event beats the clear
  // ------------------------------------------------------------
  // bit 0 corrected, bit 1 abort, bit 2 event with another error
  // irq is registered and lags the status by one cycle, a small
  // delay traded for a clean level on the pin
  wire logic [`PESIG_IRQ_W-1:0] stat_set = {evt.other & evt.valid,
                                            evt.valid & evt.promote,
                                            evt.valid & ~evt.promote};
  wire logic [`PESIG_IRQ_W-1:0] stat_clr = (wr_stat & wstrb_q[0])
                                         ? wdata_q[`PESIG_IRQ_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_q <= '0;
      mask_q <= '0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      if (wr_mask & wstrb_q[0]) begin
        mask_q <= wdata_q[`PESIG_IRQ_W-1:0];
      end
      irq <= |(stat_q & mask_q);
    end
  end

  // event counter saturates rather than wraps so software sees overflow
  // consumed events are not counted, as they are not signalled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (evt.valid && count_q != 16'hFFFF) begin
      count_q <= count_q + 16'h1;
    end
  end

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  // decode uses the captured address, so the select is stable for
  // a whole cycle before the read data register loads
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    case (araddr_q)
      `PESIG_OFF_FEAT_LO:   rd_val = feat_q[31:0];
      `PESIG_OFF_FEAT_HI:   rd_val = feat_q[63:32];
      `PESIG_OFF_SUPPORT:   rd_val = 32'(SUPPORT_PROMOTE) << (`PESIG_FEAT_PROMOTE - 32);
      `PESIG_OFF_PSTATE:    rd_val = {valid_q, 26'h0, pstate_q};
      `PESIG_OFF_CACHE_CHK: rd_val = cache_chk_q;
      `PESIG_OFF_BUS_CHK:   rd_val = bus_chk_q;
      `PESIG_OFF_IRQ_STAT:  rd_val = {29'h0, stat_q};
      `PESIG_OFF_IRQ_MASK:  rd_val = {29'h0, mask_q};
      `PESIG_OFF_CONTROL:   rd_val = {31'h0, resumable_q};
      `PESIG_OFF_COUNT:     rd_val = {16'h0, count_q};
      default:              rd_ok  = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // address and data capture, either order
  // ------------------------------------------------------------
  // ready drops for a cycle after each handshake and stays low while
  // a captured item waits, so a second write cannot overrun the first
  // the low two address bits are dropped: each register is one word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // response sequencing: one transaction at a time, writes first
  // ------------------------------------------------------------
  // a write ready to commit goes before a waiting read; a read is
  // taken by a one-cycle ready pulse and its data loaded next cycle
  // a response stands until taken; no read is accepted and no write commits
  // meanwhile, so a master that never takes it stalls the bus
  // a stray state encoding returns to idle through the default
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_q         <= PESIG_BUS_IDLE;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= '0;
      araddr_q      <= '0;
    end else begin
      s_axi_arready <= 1'b0;
      case (bus_q)
        PESIG_BUS_IDLE: begin
          if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
            bus_q        <= PESIG_BUS_WRESP;
          end else if (s_axi_arvalid & ~s_axi_arready) begin
            s_axi_arready <= 1'b1;
            araddr_q      <= {s_axi_araddr[11:2], 2'b00};
            bus_q         <= PESIG_BUS_RRESP;
          end
        end
        PESIG_BUS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_q        <= PESIG_BUS_IDLE;
          end
        end
        PESIG_BUS_RRESP: begin
          if (!s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
          end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_q        <= PESIG_BUS_IDLE;
          end
        end
        default: bus_q <= PESIG_BUS_IDLE;
      endcase
    end
  end
endmodule

// File: verif/pesig_chk_properties.sv
// concurrent checks on the poison signaller's top-level ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module pesig_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        ev_valid,
  input wire logic        ev_consumed,
  input wire logic        corrected_error_interrupt,
  input wire logic        machine_check_abort,
  input wire logic        irq,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ------------------------------------------------------------
  // event signalling
  // ------------------------------------------------------------
  AST_EVT_SIGNALLED: assert property (@(posedge clock) disable iff (sys_rst)
    ev_valid && !ev_consumed |=> corrected_error_interrupt ^ machine_check_abort)
    else $error("unconsumed event gave no single signal");
  AST_CONSUMED_SILENT: assert property (@(posedge clock) disable iff (sys_rst)
    !(ev_valid && !ev_consumed) |=> !corrected_error_interrupt && !machine_check_abort)
    else $error("signal without an unconsumed event");
  AST_ONE_KIND: assert property (@(posedge clock) disable iff (sys_rst)
    !(corrected_error_interrupt && machine_check_abort))
    else $error("both signals at once");
  AST_CE_CAUSE: assert property (@(posedge clock) disable iff (sys_rst)
    corrected_error_interrupt |-> $past(ev_valid) && !$past(ev_consumed))
    else $error("corrected interrupt without cause");
  // outputs must be quiet the edge after any reset cycle
  AST_RST_QUIET: assert property (@(posedge clock)
    sys_rst |=> !corrected_error_interrupt && !machine_check_abort && !irq
                && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  AST_RD_ANSWER: assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  AST_RV_ONCE: assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_BV_ONCE: assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_ERR_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
endmodule

bind pesig_top pesig_chk i_pesig_chk (.*);

// File: verif/pesig_bench.sv
// self-checking bench of the poison signaller through event pins and register bus
// assumes package, header, interface and design are compiled ahead of it
`timescale 1ns/1ns
`include "pesig_consts.svh"
module pesig_bench;
  logic        clock;
  logic        sys_rst;
  logic        ev_valid;
  logic        ev_consumed;
  logic        ev_cache;
  logic        ev_other;
  logic        corrected_error_interrupt;
  logic        machine_check_abort;
  logic        irq;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] rdv;
  logic [1:0]  rsp;
  int          failures;
  int          cmp_count;

  pesig_top #(.SUPPORT_PROMOTE(1'b1)) i_pesig_top (.*);

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // a wait that used its whole bound is a hang: count it and stop
  task automatic hang_check(input int n);
    if (n >= 40) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang_check(n);
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang_check(n);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(rdv & m, e);
  endtask

  // one-cycle event, then the pulse pair {corrected, abort} one cycle later
  task automatic fire(input logic c, input logic o, input logic n, input logic [1:0] e);
    @(posedge clock);
    ev_valid    <= 1'b1;
    ev_cache    <= c;
    ev_other    <= o;
    ev_consumed <= n;
    @(posedge clock);
    ev_valid <= 1'b0;
    #1;
    check({30'h0, corrected_error_interrupt, machine_check_abort}, {30'h0, e});
  endtask

  task automatic irqc(input logic e);
    @(posedge clock);
    #1;
    check({31'h0, irq}, {31'h0, e});
  endtask

  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    sys_rst = 1'b1;
    {ev_valid, ev_consumed, ev_cache, ev_other} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    failures = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(`PESIG_OFF_FEAT_HI, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`PESIG_OFF_SUPPORT, 32'h0020_0000, 32'h0020_0000);
    wr(`PESIG_OFF_IRQ_MASK, 32'h0000_0007);
    fire(1'b1, 1'b0, 1'b0, 2'b10);
    rdc(`PESIG_OFF_PSTATE, 32'hFFFF_FFFF, 32'h8000_0000 | `PESIG_ST_CORRECTED);
    rdc(`PESIG_OFF_CACHE_CHK, 32'h0080_0000, 32'h0080_0000);
    rdc(`PESIG_OFF_IRQ_STAT, 32'h0000_0007, 32'h0000_0001);
    irqc(1'b1);
    wr(`PESIG_OFF_IRQ_STAT, 32'h0000_0001);
    rdc(`PESIG_OFF_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
    irqc(1'b0);
    fire(1'b1, 1'b0, 1'b1, 2'b00);
    rdc(`PESIG_OFF_COUNT, 32'h0000_FFFF, 32'h0000_0001);
    wr(`PESIG_OFF_FEAT_HI, 32'h1000_0000);
    fire(1'b0, 1'b0, 1'b0, 2'b10);
    wr(`PESIG_OFF_FEAT_HI, 32'h1020_0000);
    rdc(`PESIG_OFF_FEAT_HI, 32'hFFFF_FFFF, 32'h1020_0000);
    fire(1'b1, 1'b0, 1'b0, 2'b01);
    rdc(`PESIG_OFF_PSTATE, 32'hFFFF_FFFF, 32'h8000_0000 | `PESIG_ST_PROMOTED);
    rdc(`PESIG_OFF_CONTROL, 32'h0000_0001, 32'h0000_0001);
    fire(1'b0, 1'b1, 1'b0, 2'b01);
    rdc(`PESIG_OFF_CONTROL, 32'h0000_0001, 32'h0000_0000);
    rdc(`PESIG_OFF_BUS_CHK, 32'h0080_0000, 32'h0080_0000);
    rdc(`PESIG_OFF_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(`PESIG_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`PESIG_OFF_IRQ_STAT, 32'h0000_0007);
    fire(1'b1, 1'b0, 1'b0, 2'b01);
    irqc(1'b0);
    wr(`PESIG_OFF_IRQ_MASK, 32'h0000_0002);
    irqc(1'b1);
    rdc(`PESIG_OFF_COUNT, 32'h0000_FFFF, 32'h0000_0005);
    wr(`PESIG_OFF_CONTROL, 32'h0000_0001);
    rdc(`PESIG_OFF_CACHE_CHK, 32'h0080_0000, 32'h0000_0000);
    rd(12'h100);
    check({30'h0, rsp}, 32'h0000_0002);
    wr(12'h100, 32'hFFFF_FFFF);
    check({30'h0, rsp}, 32'h0000_0002);
    tally_and_finish();
  end
endmodule
